//--- eba_defs.svh
// constants for the external bus arbitration block
`ifndef EBA_DEFS_SVH
`define EBA_DEFS_SVH

`define EBA_NUM_PROCS 6
`define EBA_NUM_DMA 2
`define EBA_SYNC_STAGES 2
`define EBA_ID_SINGLE 3'h0
`define EBA_MASTER_NONE 3'h0
`define EBA_CLK_PERIOD_NS 40
`define EBA_FLOAT_TIME_CLK 1
`define EBA_FLOAT_CYCLES (`EBA_FLOAT_TIME_CLK)

`endif

//--- eba_pkg.sv
// types shared by the external bus arbitration block
package eba_pkg;

   // host handover sequence
   typedef enum logic [1:0] {
      HOST_OWN,
      HOST_FLOAT,
      HOST_GRANTED
   } eba_host_state_type;

   // per channel external dma sequence
   typedef enum logic [1:0] {
      DMA_IDLE,
      DMA_GRANT,
      DMA_XFER
   } eba_dma_state_type;

endpackage : eba_pkg

//--- eba_sync.sv
// two stage synchroniser for pin inputs
`timescale 1ns/1ps
module eba_sync #(
   parameter int WIDTH = 1,
   parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
   input wire logic MCLK, // block clock
   input wire logic RST, // asynchronous reset, active high
   input wire logic [WIDTH-1:0] D, // raw pin levels
   output logic [WIDTH-1:0] Q // levels safe to use
);

   logic [WIDTH-1:0] stage1; // metastability catcher, read only by stage2

   // both stages sample on the rising edge; stage1 feeds nothing else
   always_ff @(posedge MCLK or posedge RST) begin
      if (RST) begin
         stage1 <= RESET_VAL;
         Q <= RESET_VAL;
      end else begin
         stage1 <= D;
         Q <= stage1;
      end
   end

endmodule : eba_sync

//--- eba_arbiter.sv
// external bus arbitration: host handover, external dma grants, multiprocessor requests
`timescale 1ns/1ps
`include "eba_defs.svh"
module eba_arbiter import eba_pkg::*; #(
   parameter int NUM_PROCS = `EBA_NUM_PROCS
) (
   input wire logic MCLK, // block clock, 25 MHz
   input wire logic RST, // asynchronous reset, active high
   input wire logic HOST_REQUEST_N, // host wants the bus, pin
   input wire logic HOST_SELECT_N, // host selects this device, pin
   input wire logic HOST_GRANT_N_I, // host grant wire level
   output logic HOST_GRANT_N_O, // host grant drive value
   output logic HOST_GRANT_N_OE, // host grant drive enable
   output logic HOST_ACK_O, // open drain acknowledge value
   output logic HOST_ACK_OE, // acknowledge pulled low while high
   input wire logic EXT_DMA_REQ_A_N, // dma request, channel a, pin
   input wire logic EXT_DMA_REQ_B_N, // dma request, channel b, pin
   output logic EXT_DMA_GNT_A_N, // dma grant, channel a
   output logic EXT_DMA_GNT_A_OE, // dma grant a drive enable
   output logic EXT_DMA_GNT_B_N, // dma grant, channel b
   output logic EXT_DMA_GNT_B_OE, // dma grant b drive enable
   input wire logic [NUM_PROCS-1:0] MP_BUS_REQUEST_N_I, // request wire levels
   output logic [NUM_PROCS-1:0] MP_BUS_REQUEST_N_O, // request drive values
   output logic [NUM_PROCS-1:0] MP_BUS_REQUEST_N_OE, // only own line enabled
   input wire logic [2:0] PROC_NUMBER, // processor number strap
   input wire logic ROTATE_PRIO_SEL, // high rotating, low fixed
   input wire logic PRIORITY_ACCESS_N_I, // priority access wire level
   output logic PRIORITY_ACCESS_N_O, // priority access drive value
   output logic PRIORITY_ACCESS_N_OE, // priority access drive enable
   output logic OWNS_BUS, // this processor owns the bus
   output logic EXT_BUS_FLOAT, // address, data, select, strobes float
   input wire logic CORE_BUS_REQ, // core wants the bus
   input wire logic CORE_PRIO_ACCESS, // core wants urgent access as slave
   input wire logic DMA_DONE_A, // channel a transfer finished
   input wire logic DMA_DONE_B, // channel b transfer finished
   output logic DMA_START_A, // channel a starts, one cycle pulse
   output logic DMA_START_B // channel b starts, one cycle pulse
);

   localparam int SW = NUM_PROCS + 10; // synchronised bit count
   localparam logic [SW-1:0] SYNC_RST = {5'h1F, {NUM_PROCS{1'h1}}, 1'h1, 1'h0, 3'h0};

   logic [SW-1:0] sync_q; // synchronised pin levels
   logic host_req_s; // host request, active low
   logic host_sel_s; // host select, active low
   logic host_gnt_s; // observed host grant, active low
   logic [`EBA_NUM_DMA-1:0] dma_req; // dma requests, active high
   logic [NUM_PROCS-1:0] mp_req; // bus requests, active high
   logic pa_s; // priority access wire, active low
   logic rot_s; // rotating priority select
   logic [2:0] proc_id; // processor number

   // every pin passes the synchroniser before use
   eba_sync #(
      .WIDTH(SW),
      .RESET_VAL(SYNC_RST)
   ) u_sync (
      .MCLK(MCLK),
      .RST(RST),
      .D({HOST_REQUEST_N, HOST_SELECT_N, HOST_GRANT_N_I, EXT_DMA_REQ_B_N, EXT_DMA_REQ_A_N,
          MP_BUS_REQUEST_N_I, PRIORITY_ACCESS_N_I, ROTATE_PRIO_SEL, PROC_NUMBER}),
      .Q(sync_q)
   );

   // unpack the synchronised vector
   always_comb begin
      {host_req_s, host_sel_s, host_gnt_s} = sync_q[SW-1 -: 3];
      dma_req = ~sync_q[SW-4 -: 2];
      mp_req = ~sync_q[NUM_PROCS+4 : 5];
      pa_s = sync_q[4];
      rot_s = sync_q[3];
      proc_id = sync_q[2:0];
   end

   eba_host_state_type host_state; // host handover state
   eba_host_state_type next_host_state; // its next value
   logic [2:0] current_master; // number of bus master, zero for none
   logic [2:0] last_master; // last winner, rotation start point
   logic single; // single processor system
   logic is_master; // this processor is master now
   logic host_hold; // host has or is taking the bus
   logic arb_open; // master free to change this cycle
   logic [2:0] winner; // arbitration result
   logic [2:0] fixed_pick; // fixed priority result, for checking
   logic own_req; // own request line value, active high
   logic next_own_req; // its next value
   logic pa_drive; // driving priority access
   eba_dma_state_type dma_state [`EBA_NUM_DMA]; // per channel state
   logic [`EBA_NUM_DMA-1:0] dma_gnt; // grant pulse, active high
   logic [`EBA_NUM_DMA-1:0] dma_start; // start strobe to dma engine
   logic [`EBA_NUM_DMA-1:0] dma_done; // finish strobes
   logic [`EBA_NUM_DMA-1:0] dma_busy; // channel not idle
   logic dma_oe; // dma grants driven

   // lowest request wins when fixed; when rotating the line after the last winner leads
   function automatic logic [2:0] pick_winner(input logic [NUM_PROCS-1:0] req, input logic rot,
                                              input logic [2:0] last);
      logic [2:0] win;
      int idx;
      win = `EBA_MASTER_NONE;
      for (int k = NUM_PROCS - 1; k >= 0; k--) begin
         idx = rot ? (int'(last) + k) % NUM_PROCS : k;
         if (req[idx]) begin
            win = 3'(idx + 1);
         end
      end
      return win;
   endfunction : pick_winner

   assign single = (proc_id == `EBA_ID_SINGLE);
   assign is_master = single || (current_master == proc_id);
   assign host_hold = !host_req_s || !host_gnt_s || (host_state != HOST_OWN);
   assign winner = pick_winner(mp_req, rot_s, last_master);
   assign fixed_pick = pick_winner(mp_req, 1'h0, last_master);
   // the master keeps the bus while it still requests it
   assign arb_open = !host_hold &&
      ((current_master == `EBA_MASTER_NONE) || !mp_req[3'(current_master - 3'h1)]);

   // all processors see the same lines and run the same choice
   always_ff @(posedge MCLK or posedge RST) begin
      if (RST) begin
         current_master <= `EBA_MASTER_NONE;
         last_master <= `EBA_MASTER_NONE;
      end else if (arb_open) begin
         current_master <= winner;
         if (winner != `EBA_MASTER_NONE) begin
            last_master <= winner;
         end
      end
   end

   // own request: core work or dma work; a background-only master yields to priority access
   always_comb begin
      next_own_req = CORE_BUS_REQ || (|dma_req) || (|dma_busy);
      if (is_master && !pa_s && !pa_drive && !CORE_BUS_REQ) begin
         next_own_req = 1'h0;
      end
   end

   always_ff @(posedge MCLK or posedge RST) begin
      if (RST) begin
         own_req <= 1'h0;
      end else begin
         own_req <= next_own_req;
      end
   end

   // only the line picked by the processor number is driven; the rest are watched
   for (genvar i = 0; i < NUM_PROCS; i++) begin : g_req_line
      assign MP_BUS_REQUEST_N_O[i] = !own_req;
      assign MP_BUS_REQUEST_N_OE[i] = (proc_id == 3'(i + 1));
   end

   // priority access: a slave pulls the shared line low while it wants urgent access
   always_ff @(posedge MCLK or posedge RST) begin
      if (RST) begin
         pa_drive <= 1'h0;
      end else begin
         pa_drive <= CORE_PRIO_ACCESS && !is_master && !single;
      end
   end
   assign PRIORITY_ACCESS_N_O = 1'h0;
   assign PRIORITY_ACCESS_N_OE = pa_drive;

   // host handover: float one clock, then grant until the request goes away
   always_comb begin
      next_host_state = host_state;
      case (host_state)
         HOST_OWN: begin
            if (!host_req_s && is_master) begin
               next_host_state = HOST_FLOAT;
            end
         end
         HOST_FLOAT: begin
            next_host_state = HOST_GRANTED;
         end
         HOST_GRANTED: begin
            if (host_req_s) begin
               next_host_state = HOST_OWN;
            end
         end
         default: begin
            next_host_state = HOST_OWN;
         end
      endcase
   end

   always_ff @(posedge MCLK or posedge RST) begin
      if (RST) begin
         host_state <= HOST_OWN;
      end else begin
         host_state <= next_host_state;
      end
   end

   // grant pin from flops; only the master ever enables it
   always_ff @(posedge MCLK or posedge RST) begin
      if (RST) begin
         HOST_GRANT_N_O <= 1'h1;
         HOST_GRANT_N_OE <= 1'h0;
      end else begin
         case (next_host_state)
            HOST_FLOAT: begin
               HOST_GRANT_N_O <= 1'h1;
               HOST_GRANT_N_OE <= 1'h0;
            end
            HOST_GRANTED: begin
               HOST_GRANT_N_O <= 1'h0;
               HOST_GRANT_N_OE <= 1'h1;
            end
            default: begin
               HOST_GRANT_N_O <= 1'h1;
               HOST_GRANT_N_OE <= is_master && !single;
            end
         endcase
      end
   end

   // bus drivers float before the grant and stay off while the host or a peer holds it
   always_ff @(posedge MCLK or posedge RST) begin
      if (RST) begin
         EXT_BUS_FLOAT <= 1'h1;
         OWNS_BUS <= 1'h0;
      end else begin
         EXT_BUS_FLOAT <= (next_host_state != HOST_OWN) || !is_master;
         OWNS_BUS <= single || (is_master && !host_hold);
      end
   end

   // wait states for host register accesses while select and request are both low
   always_ff @(posedge MCLK or posedge RST) begin
      if (RST) begin
         HOST_ACK_OE <= 1'h0;
      end else begin
         HOST_ACK_OE <= !host_sel_s && !host_req_s;
      end
   end
   assign HOST_ACK_O = 1'h0;

   assign dma_done = {DMA_DONE_B, DMA_DONE_A};

   // external dma channels; channel a outranks channel b, one runs at a time
   for (genvar c = 0; c < `EBA_NUM_DMA; c++) begin : g_dma
      logic go; // this channel may start
      assign dma_busy[c] = (dma_state[c] != DMA_IDLE);
      if (c == 0) begin : g_first
         assign go = dma_req[c] && (dma_busy == '0);
      end else begin : g_rest
         assign go = dma_req[c] && (dma_busy == '0) && (dma_req[c-1:0] == '0);
      end

      always_ff @(posedge MCLK or posedge RST) begin
         if (RST) begin
            dma_state[c] <= DMA_IDLE;
            dma_gnt[c] <= 1'h0;
            dma_start[c] <= 1'h0;
         end else begin
            dma_gnt[c] <= 1'h0;
            dma_start[c] <= 1'h0;
            case (dma_state[c])
               DMA_IDLE: begin
                  if (go && OWNS_BUS && !host_hold) begin
                     dma_state[c] <= DMA_GRANT;
                     dma_gnt[c] <= 1'h1;
                  end
               end
               DMA_GRANT: begin
                  dma_state[c] <= DMA_XFER; // transfer starts the cycle after the grant
                  dma_start[c] <= 1'h1;
               end
               DMA_XFER: begin
                  if (dma_done[c]) begin
                     dma_state[c] <= DMA_IDLE;
                  end
               end
               default: begin
                  dma_state[c] <= DMA_IDLE;
               end
            endcase
         end
      end
   end

   // grants are enabled by the master only
   always_ff @(posedge MCLK or posedge RST) begin
      if (RST) begin
         dma_oe <= 1'h0;
      end else begin
         dma_oe <= is_master;
      end
   end
   assign EXT_DMA_GNT_A_N = !dma_gnt[0];
   assign EXT_DMA_GNT_B_N = !dma_gnt[1];
   assign EXT_DMA_GNT_A_OE = dma_oe;
   assign EXT_DMA_GNT_B_OE = dma_oe;
   assign DMA_START_A = dma_start[0];
   assign DMA_START_B = dma_start[1];

   // checks on the arbitration behaviour
   default clocking cb @(posedge MCLK); endclocking
   default disable iff (RST);

   property p_grant_answer;
      (host_state == HOST_OWN && is_master && !host_req_s) |=> ##1 (!HOST_GRANT_N_O && HOST_GRANT_N_OE);
   endproperty
   a_grant_answer: assert property (p_grant_answer) else $error("host grant not given");

   property p_grant_hold;
      (host_state == HOST_GRANTED && !host_req_s) |=> (!HOST_GRANT_N_O && HOST_GRANT_N_OE);
   endproperty
   a_grant_hold: assert property (p_grant_hold) else $error("host grant dropped early");

   property p_grant_release;
      (host_state == HOST_GRANTED && host_req_s) |=> HOST_GRANT_N_O;
   endproperty
   a_grant_release: assert property (p_grant_release) else $error("host grant kept after release");

   property p_float_one;
      (host_state == HOST_FLOAT) |-> !HOST_GRANT_N_OE ##1 (HOST_GRANT_N_OE && !HOST_GRANT_N_O);
   endproperty
   a_float_one: assert property (p_float_one) else $error("grant float not one cycle");

   property p_grant_master;
      $rose(HOST_GRANT_N_OE) |-> $past(is_master);
   endproperty
   a_grant_master: assert property (p_grant_master) else $error("non-master drives host grant");

   property p_ack_wait;
      (!host_sel_s && !host_req_s) |=> HOST_ACK_OE;
   endproperty
   a_ack_wait: assert property (p_ack_wait) else $error("no wait state on host access");

   property p_dma_pulse;
      !EXT_DMA_GNT_A_N |-> EXT_DMA_GNT_A_OE ##1 (EXT_DMA_GNT_A_N && DMA_START_A);
   endproperty
   a_dma_pulse: assert property (p_dma_pulse) else $error("dma grant a not followed by start");

   property p_own_line;
      (proc_id != 3'h0 && int'(proc_id) <= NUM_PROCS) |-> ($onehot(MP_BUS_REQUEST_N_OE) &&
         MP_BUS_REQUEST_N_OE[3'(proc_id - 3'h1)]);
   endproperty
   a_own_line: assert property (p_own_line) else $error("wrong request line driven");

   property p_owns_master;
      OWNS_BUS |-> $past(is_master);
   endproperty
   a_owns_master: assert property (p_owns_master) else $error("owns bus while not master");

   property p_single_owns;
      // the owner flag is still in reset at the first edge after release
      (single && $past(single) && !$past(RST)) |-> OWNS_BUS;
   endproperty
   a_single_owns: assert property (p_single_owns) else $error("single processor not owner");

   property p_fixed_prio;
      (arb_open && !rot_s) |=> (current_master == $past(fixed_pick));
   endproperty
   a_fixed_prio: assert property (p_fixed_prio) else $error("fixed priority not lowest");

   property p_host_first;
      (host_hold && !arb_open) |=> $stable(current_master);
   endproperty
   a_host_first: assert property (p_host_first) else $error("master changed under host");

   property p_float_before_grant;
      (host_state == HOST_FLOAT) |-> EXT_BUS_FLOAT;
   endproperty
   a_float_before_grant: assert property (p_float_before_grant) else $error("bus driven at handover");

   property p_pa_drive;
      (CORE_PRIO_ACCESS && !is_master && !single) |=> (PRIORITY_ACCESS_N_OE && !PRIORITY_ACCESS_N_O);
   endproperty
   a_pa_drive: assert property (p_pa_drive) else $error("priority access not driven");

   c_host_granted: cover property (host_state == HOST_FLOAT ##1 host_state == HOST_GRANTED);
   c_dma_b_start: cover property (DMA_START_B);
   c_rotate_switch: cover property (arb_open && rot_s && winner != `EBA_MASTER_NONE);
   c_pa_yield: cover property (is_master && !pa_s && !CORE_BUS_REQ);

endmodule : eba_arbiter

//--- eba_far_side.sv
// far side model: host, peer processors and external dma peripherals
`timescale 1ns/1ps
module eba_far_side (
   input wire logic mclk, // block clock
   input wire logic rst, // reset, active high
   input wire logic want_host, // host wants the bus
   input wire logic want_sel, // host addresses the device
   input wire logic [1:0] want_dma, // peripherals a, b want service
   input wire logic [5:0] peer_req, // peers asking for the bus
   input wire logic peer_pa, // a peer pulls priority access
   input wire logic grant_o, // device host grant value
   input wire logic grant_oe, // device host grant enable
   input wire logic [1:0] gnt_n, // device dma grants
   input wire logic [1:0] gnt_oe, // device dma grant enables
   input wire logic [5:0] req_o, // device request values
   input wire logic [5:0] req_oe, // device request enables
   input wire logic pa_oe, // device pulls priority access
   output logic host_req_n, // host request pin
   output logic host_sel_n, // host select pin
   output logic grant_wire, // resolved host grant line
   output logic [1:0] dma_req_n, // dma request pins
   output logic [5:0] req_wire, // resolved request lines
   output logic pa_wire // resolved priority access line
);
   logic [1:0] served; // grant seen, wait for the wish to drop
   logic [1:0] gnt_wire; // resolved dma grant lines
   // host pins follow the host's wishes directly
   assign host_req_n = !want_host;
   assign host_sel_n = !want_sel;
   // all shared lines are pulled up, so an undriven line reads high
   assign grant_wire = grant_oe ? grant_o : 1'b1;
   assign gnt_wire = (gnt_oe & gnt_n) | ~gnt_oe;
   assign req_wire = (req_oe & req_o) | (~req_oe & ~peer_req);
   assign pa_wire = !(pa_oe || peer_pa);
   // a peripheral holds its request until it sees its grant, then lets go
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         dma_req_n <= 2'h3;
         served <= 2'h0;
      end else begin
         for (int i = 0; i < 2; i++) begin
            if (!gnt_wire[i]) begin
               dma_req_n[i] <= 1'b1; // released once granted
               served[i] <= 1'b1;
            end else if (!want_dma[i]) begin
               served[i] <= 1'b0;
            end else if (!served[i]) begin
               dma_req_n[i] <= 1'b0;
            end
         end
      end
   end
endmodule : eba_far_side

//--- tb_external_bus_arbitration.sv
// self-checking bench for the external bus arbiter
`timescale 1ns/1ps
module tb_external_bus_arbitration;
   localparam int LIMIT = 5000; // run needs well under a thousand cycles
   logic mclk = 1'b0; // block clock
   logic rst = 1'b1; // reset, active high
   logic want_host = 1'b0; // host wish
   logic want_sel = 1'b0; // host select wish
   logic peer_pa = 1'b0; // peer priority access
   logic [1:0] want_dma = 2'h0; // peripheral wishes
   logic [5:0] peer_req = 6'h00; // peer bus requests
   logic [2:0] proc_number = 3'h0; // processor number strap
   logic rotate = 1'b0; // priority mode
   logic core_req = 1'b0; // core wants the bus
   logic core_pa = 1'b0; // core wants priority access
   logic [1:0] dma_done = 2'h0; // transfer end pulses
   logic host_req_n, host_sel_n, grant_wire, pa_wire, grant_o, grant_oe, ack_o, ack_oe; // host side
   logic [1:0] dma_req_n, gnt_n, gnt_oe, dma_start; // dma side
   logic [5:0] req_wire, req_o, req_oe; // request lines
   logic pa_o, pa_oe, owns, bus_float; // remaining outputs
   int miscompares = 0; // failed comparisons
   int check_count = 0; // comparisons made
   int cycles = 0; // clock cycles run
   int n, q, r, k; // numbers of us, holder, rival; loop index
   logic flag; // stays high while a level persists

   eba_arbiter i_eba_arbiter (.MCLK(mclk), .RST(rst), .HOST_REQUEST_N(host_req_n), .HOST_SELECT_N(host_sel_n),
      .HOST_GRANT_N_I(grant_wire), .HOST_GRANT_N_O(grant_o), .HOST_GRANT_N_OE(grant_oe), .HOST_ACK_O(ack_o),
      .HOST_ACK_OE(ack_oe), .EXT_DMA_REQ_A_N(dma_req_n[0]), .EXT_DMA_REQ_B_N(dma_req_n[1]),
      .EXT_DMA_GNT_A_N(gnt_n[0]), .EXT_DMA_GNT_A_OE(gnt_oe[0]), .EXT_DMA_GNT_B_N(gnt_n[1]),
      .EXT_DMA_GNT_B_OE(gnt_oe[1]), .MP_BUS_REQUEST_N_I(req_wire), .MP_BUS_REQUEST_N_O(req_o),
      .MP_BUS_REQUEST_N_OE(req_oe), .PROC_NUMBER(proc_number), .ROTATE_PRIO_SEL(rotate),
      .PRIORITY_ACCESS_N_I(pa_wire), .PRIORITY_ACCESS_N_O(pa_o), .PRIORITY_ACCESS_N_OE(pa_oe), .OWNS_BUS(owns),
      .EXT_BUS_FLOAT(bus_float), .CORE_BUS_REQ(core_req), .CORE_PRIO_ACCESS(core_pa), .DMA_DONE_A(dma_done[0]),
      .DMA_DONE_B(dma_done[1]), .DMA_START_A(dma_start[0]), .DMA_START_B(dma_start[1]));

   eba_far_side i_eba_far_side (.mclk(mclk), .rst(rst), .want_host(want_host), .want_sel(want_sel),
      .want_dma(want_dma), .peer_req(peer_req), .peer_pa(peer_pa), .grant_o(grant_o), .grant_oe(grant_oe),
      .gnt_n(gnt_n), .gnt_oe(gnt_oe), .req_o(req_o), .req_oe(req_oe), .pa_oe(pa_oe), .host_req_n(host_req_n),
      .host_sel_n(host_sel_n), .grant_wire(grant_wire), .dma_req_n(dma_req_n), .req_wire(req_wire),
      .pa_wire(pa_wire));

   // free running clock, 40 ns period
   initial begin
      forever #20 mclk = !mclk;
   end

   // hang guard: counts as a failure and closes the run
   always @(posedge mclk) begin
      cycles++;
      if (cycles == LIMIT) begin
         miscompares++;
         print_verdict();
      end
   end

   // compare one observed value with the model's value
   task automatic check(input logic [5:0] got, input logic [5:0] exp, input string what);
      check_count++;
      if (got !== exp) begin
         miscompares++;
         $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
      end
   endtask : check

   // counts, then the single verdict
   task automatic print_verdict();
      $display("comparisons %0d, mismatches %0d", check_count, miscompares);
      if (miscompares == 0 && check_count > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask : print_verdict

   // settle to falling edges so registered outputs have landed
   task automatic ticks(input int c);
      repeat (c) @(negedge mclk);
   endtask : ticks

   // reset is the only time the number strap may change
   task automatic do_reset(input logic [2:0] num);
      rst <= 1'b1;
      proc_number <= num;
      repeat (6) @(posedge mclk);
      rst <= 1'b0;
      ticks(4);
   endtask : do_reset

   // model of the arbitration: fixed takes the lowest line, rotating starts after the last winner
   function automatic int pick(input logic [5:0] m, input int last, input int rot);
      int i;
      for (int s = 0; s < 6; s++) begin
         i = (rot == 1) ? (last + s) % 6 : s;
         if (m[i] === 1'b1) return i + 1;
      end
      return 0;
   endfunction : pick

   // full host handover: pin low, two sync edges, float edge, grant edge, release
   task automatic host_cycle(input logic drv, input logic own_held);
      @(posedge mclk);
      want_host <= 1'b1;
      want_sel <= 1'b1;
      ticks(3);
      check({5'h00, grant_oe}, {5'h00, drv}, "grant enable before handover");
      check({5'h00, ack_oe}, 6'h00, "acknowledge before sync");
      ticks(1);
      check({4'h0, grant_oe, bus_float}, 6'h01, "grant floats, bus off");
      check({5'h00, ack_oe}, 6'h01, "wait state inserted");
      ticks(1);
      check({4'h0, grant_o, grant_oe}, 6'h01, "grant given");
      check({5'h00, owns}, {5'h00, own_held}, "owner flag under host");
      flag = 1'b1;
      repeat (6) begin
         ticks(1);
         if (grant_o !== 1'b0) flag = 1'b0;
      end
      check({5'h00, flag}, 6'h01, "grant held low");
      @(posedge mclk);
      want_host <= 1'b0;
      want_sel <= 1'b0;
      ticks(3);
      check({5'h00, grant_o}, 6'h00, "grant kept until release seen");
      ticks(1);
      check({5'h00, grant_o}, 6'h01, "grant released");
   endtask : host_cycle

   initial begin
      k = $urandom(32'hb56e);
      q = $urandom_range(5, 2);
      if ($urandom_range(1, 0) == 1) begin
         n = $urandom_range(6, q + 1);
         r = $urandom_range(q - 1, 1);
      end else begin
         n = $urandom_range(q - 1, 1);
         r = $urandom_range(6, q + 1);
      end
      // single processor system
      do_reset(3'h0);
      check({5'h00, owns}, 6'h01, "single processor owns bus");
      check(req_oe, 6'h00, "no request line for number zero");
      host_cycle(1'b0, 1'b1);
      $display("test single processor done");
      // multiprocessor system with a random number
      @(posedge mclk);
      do_reset(n[2:0]);
      check(req_oe, 6'h01 << (n - 1), "only own request line driven");
      for (int rot = 0; rot < 2; rot++) begin
         @(posedge mclk);
         rotate <= rot[0];
         peer_req[q - 1] <= 1'b1;
         ticks(12);
         check({3'h0, owns, gnt_oe}, 6'h00, "slave neither owns nor grants");
         if (rot == 0) begin
            @(posedge mclk);
            core_pa <= 1'b1;
            ticks(8);
            check({5'h00, pa_oe}, 6'h01, "slave pulls priority access");
            @(posedge mclk);
            core_pa <= 1'b0;
            want_host <= 1'b1;
            flag = 1'b1;
            repeat (8) begin
               ticks(1);
               if (grant_oe !== 1'b0) flag = 1'b0;
            end
            check({5'h00, flag}, 6'h01, "slave leaves host grant undriven");
            @(posedge mclk);
            want_host <= 1'b0;
            ticks(6);
         end
         @(posedge mclk);
         core_req <= 1'b1;
         peer_req[r - 1] <= 1'b1;
         ticks(8);
         check({5'h00, owns}, 6'h00, "master kept while its line is low");
         @(posedge mclk);
         peer_req[q - 1] <= 1'b0;
         ticks(12);
         check({5'h00, owns}, {5'h00, pick((6'h01 << (n - 1)) | (6'h01 << (r - 1)), q, rot) == n},
            "arbitration winner");
         @(posedge mclk);
         core_req <= 1'b0;
         peer_req <= 6'h00;
         ticks(12);
         $display("test arbitration mode %0d done", rot);
      end
      // we become master, then the host takes over
      @(posedge mclk);
      core_req <= 1'b1;
      for (k = 0; k < 20 && owns !== 1'b1; k++) ticks(1);
      check({4'h0, owns, req_wire[n - 1]}, 6'h02, "core wins idle bus on own line");
      host_cycle(1'b1, 1'b0);
      for (k = 0; k < 20 && owns !== 1'b1; k++) ticks(1);
      check({5'h00, owns}, 6'h01, "ownership back after host");
      $display("test host handover done");
      // external dma, both channels at once: a first, b after a ends
      @(posedge mclk);
      want_dma <= 2'h3;
      for (k = 0; k < 20 && gnt_n[0] !== 1'b0; k++) ticks(1);
      check({2'h0, gnt_oe, gnt_n}, 6'h0E, "channel a granted first");
      ticks(1);
      check({2'h0, dma_start, gnt_n}, 6'h07, "a starts after its grant");
      flag = 1'b1;
      repeat (6) begin
         ticks(1);
         if (gnt_n[1] !== 1'b1 || dma_start !== 2'h0) flag = 1'b0;
      end
      check({5'h00, flag}, 6'h01, "b waits while a busy");
      @(posedge mclk);
      dma_done <= 2'h1;
      want_dma[0] <= 1'b0;
      @(posedge mclk);
      dma_done <= 2'h0;
      for (k = 0; k < 20 && gnt_n[1] !== 1'b0; k++) ticks(1);
      check({4'h0, gnt_n}, 6'h01, "channel b granted after a ends");
      ticks(1);
      check({4'h0, dma_start}, 6'h02, "b starts after its grant");
      @(posedge mclk);
      dma_done <= 2'h2;
      want_dma <= 2'h0;
      @(posedge mclk);
      dma_done <= 2'h0;
      ticks(4);
      $display("test external dma done");
      print_verdict();
   end
endmodule : tb_external_bus_arbitration
